// ===== include/clkdist_defines.svh
// constants for the clock distribution and oscillator calibration block
`ifndef CLKDIST_DEFINES_SVH
`define CLKDIST_DEFINES_SVH
`define NCH         14
`define A_CAL       10'h0f3
`define A_PRE       10'h0f5
`define A_STAT      10'h22d
`define A_SYNC      10'h232
`define A_COMMIT    10'h234
`define A_CH_BASE   10'h190
`define CH_BYTES    3
`define B_CAL       1
`define B_BUSY      0
`define B_SYNC      0
`define B_COMMIT    0
`define F_INV       4
`define F_IGN       5
`define F_PD        6
`define F_SRC       7
`define MODE_TRI    4'hf
`define CH_RST      24'h000000
`define PRE_RST     4'h0
`define CAL_CYCLES  1024
`endif

// ===== include/clkdist_pkg.sv
// types for the clock distribution and oscillator calibration block
`default_nettype none
package clkdist_pkg;
   typedef enum logic [1:0] {
      CAL_IDLE = 2'h0,
      CAL_RUN  = 2'h1,
      CAL_LOCK = 2'h3
   } cal_state_t;
endpackage
`default_nettype wire

// ===== hdl/prescale_div.sv
// oscillator prescale divider with half-period ticks
`default_nettype none
`include "clkdist_defines.svh"
module prescale_div (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // control
   input  wire logic       i_run,
   input  wire logic [1:0] i_code,
   // half-period tick
   output logic            o_tick
);
   logic [2:0] cnt_q;
   logic [2:0] last;

   // ratio 3, 4 or 5 from code; code 3 also gives 5
   assign last = (i_code == 2'h0) ? 3'h2 : (i_code == 2'h1) ? 3'h3 : 3'h4;

   // free counter; only reset and deep sleep touch it, never alignment
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= 3'h0;
      end else if (!i_run) begin
         cnt_q <= 3'h0;
      end else if (cnt_q >= last) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   // tick at start and middle of each period
   assign o_tick = i_run && (cnt_q == 3'h0 || cnt_q == (last + 3'h1) >> 1);

   property p_wrap;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_run && cnt_q == last && $stable(i_code)) |=> cnt_q == 3'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("prescaler ratio wrong");
endmodule // prescale_div
`default_nettype wire

// ===== hdl/chan_div.sv
// channel divider with phase preset, hold and power-down
`default_nettype none
`include "clkdist_defines.svh"
module chan_div (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // input half-period tick and controls
   input  wire logic       i_tick,
   input  wire logic       i_hold,
   input  wire logic       i_pd,
   input  wire logic [9:0] i_div,
   input  wire logic [5:0] i_phase,
   // divided clock
   output logic            o_clk
);
   logic [9:0] cnt_q;
   logic [5:0] ph_q;

   // toggle every div+1 half periods: exact 50% for odd ratios only at prescale ratio 4
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= 10'h000;
         ph_q  <= 6'h00;
         o_clk <= 1'b0;
      end else if (i_pd || i_hold) begin
         cnt_q <= 10'h000;
         ph_q  <= i_phase;
         o_clk <= 1'b0;
      end else if (i_tick) begin
         if (ph_q != 6'h00) begin
            ph_q <= ph_q - 6'h01;
         end else if (cnt_q == i_div) begin
            cnt_q <= 10'h000;
            o_clk <= ~o_clk;
         end else begin
            cnt_q <= cnt_q + 10'h001;
         end
      end
   end

   property p_pd_stop;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_pd |=> !o_clk && cnt_q == 10'h000;
   endproperty
   a_pd_stop: assert property (p_pd_stop) else $error("channel not stopped");

   property p_toggle;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!i_pd && !i_hold && i_tick && ph_q == 6'h00 && cnt_q == i_div) |=> $changed(o_clk);
   endproperty
   a_toggle: assert property (p_toggle) else $error("missed divider toggle");
endmodule // chan_div
`default_nettype wire

// ===== hdl/clock_distribution_vco_cal.sv
// clock distribution channels with oscillator calibration controller
`default_nettype none
`include "clkdist_defines.svh"
module clock_distribution_vco_cal #(
   parameter int CAL_CYCLES = `CAL_CYCLES
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset_n,
   // register port
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   input  wire logic [9:0]        i_reg_addr,
   input  wire logic [7:0]        i_reg_wdata,
   output logic      [7:0]        o_reg_rdata,
   // pins and loop status
   input  wire logic              i_ref_osc,
   input  wire logic              i_sync_n,
   input  wire logic              i_loop_locked,
   input  wire logic              i_nvm_load_done,
   // channel outputs, deep sleep flag and calibration state
   output logic      [13:0]       o_out,
   output logic      [13:0]       o_out_oe,
   output logic      [55:0]       o_out_mode,
   output logic                   o_deep_sleep,
   output var clkdist_pkg::cal_state_t o_cal_state
);
   import clkdist_pkg::*;

   logic [3:0]  s1_q;
   logic [3:0]  s2_q;
   logic        ref_prev_q;
   logic        nvm_prev_q;
   logic        cal_sh_q;
   logic        cal_act_q;
   logic        cal_prev_q;
   logic [3:0]  pre_sh_q;
   logic [3:0]  pre_act_q;
   logic        sync_bit_q;
   logic        commit_q;
   logic [23:0] ch_sh_q [`NCH];
   logic [23:0] ch_act_q [`NCH];
   cal_state_t  cal_q;
   logic [15:0] cal_cnt_q;
   logic        pend_q;
   logic        first_done_q;
   logic        released_q;
   logic        ref_rise;
   logic        nvm_rise;
   logic        busy;
   logic        hold;
   logic        strobe;
   logic        all_pd;
   logic [1:0]  pre_tick;
   logic [13:0] dclk;
   logic [13:0] held;
   logic [13:0] pd_vec;
   logic [7:0]  rd_d;

   // which channel register an address hits; 15 when none
   function automatic logic [3:0] ch_of(input logic [9:0] a);
      ch_of = 4'hf;
      for (int i = 0; i < `NCH; i++) begin
         if (a >= `A_CH_BASE + 10'(i * `CH_BYTES) &&
             a < `A_CH_BASE + 10'((i + 1) * `CH_BYTES)) begin
            ch_of = 4'(i);
         end
      end
   endfunction

   // byte of a channel register an address hits
   function automatic logic [1:0] byte_of(input logic [9:0] a, input logic [3:0] c);
      byte_of = 2'(a - `A_CH_BASE - 10'(c) * 10'(`CH_BYTES));
   endfunction

   // two-flop synchronisers for ref clock, sync pin, lock and load done
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_q <= 4'h2;
         s2_q <= 4'h2;
      end else begin
         s1_q <= {i_nvm_load_done, i_loop_locked, i_sync_n, i_ref_osc};
         s2_q <= s1_q;
      end
   end

   // edge detectors on synchronised reference clock and load done
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ref_prev_q <= 1'b0;
         nvm_prev_q <= 1'b0;
      end else begin
         ref_prev_q <= s2_q[0];
         nvm_prev_q <= s2_q[3];
      end
   end
   assign ref_rise = s2_q[0] && !ref_prev_q;
   assign nvm_rise = s2_q[3] && !nvm_prev_q;

   // shadow registers written by the host
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cal_sh_q   <= 1'b0;
         pre_sh_q   <= `PRE_RST;
         sync_bit_q <= 1'b0;
         for (int i = 0; i < `NCH; i++) begin
            ch_sh_q[i] <= `CH_RST;
         end
      end else if (i_reg_wr) begin
         if (i_reg_addr == `A_CAL) begin
            cal_sh_q <= i_reg_wdata[`B_CAL];
         end
         if (i_reg_addr == `A_PRE) begin
            pre_sh_q <= i_reg_wdata[3:0];
         end
         if (i_reg_addr == `A_SYNC) begin
            sync_bit_q <= i_reg_wdata[`B_SYNC];
         end
         if (ch_of(i_reg_addr) != 4'hf) begin
            ch_sh_q[ch_of(i_reg_addr)][8*byte_of(i_reg_addr, ch_of(i_reg_addr)) +: 8]
               <= i_reg_wdata;
         end
      end
   end

   // commit bit: set by write, cleared one cycle later, set wins
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         commit_q <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == `A_COMMIT && i_reg_wdata[`B_COMMIT]) begin
         commit_q <= 1'b1;
      end else begin
         commit_q <= 1'b0;
      end
   end

   // active copies updated only on commit
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cal_act_q <= 1'b0;
         pre_act_q <= `PRE_RST;
         for (int i = 0; i < `NCH; i++) begin
            ch_act_q[i] <= `CH_RST;
         end
      end else if (commit_q) begin
         cal_act_q <= cal_sh_q;
         pre_act_q <= pre_sh_q;
         for (int i = 0; i < `NCH; i++) begin
            ch_act_q[i] <= ch_sh_q[i];
         end
      end
   end

   // start request from a rising calibrate bit or a stored load completing while the calibrate bit is set
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cal_prev_q <= 1'b0;
         pend_q     <= 1'b0;
      end else begin
         cal_prev_q <= cal_act_q;
         if ((cal_act_q && !cal_prev_q) || (nvm_rise && cal_act_q)) begin
            pend_q <= 1'b1;
         end else if (ref_rise && cal_q == CAL_IDLE) begin
            pend_q <= 1'b0;
         end
      end
   end

   // calibration controller, advancing on reference clock edges
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cal_q     <= CAL_IDLE;
         cal_cnt_q <= 16'h0000;
      end else if (ref_rise) begin
         case (cal_q)
            CAL_IDLE: begin
               cal_cnt_q <= 16'h0000;
               if (pend_q) begin
                  cal_q <= CAL_RUN;
               end
            end
            CAL_RUN: begin
               cal_cnt_q <= cal_cnt_q + 16'h0001;
               if (cal_cnt_q == 16'(CAL_CYCLES - 1)) begin
                  cal_q <= CAL_LOCK;
               end
            end
            CAL_LOCK: begin
               if (s2_q[2]) begin
                  cal_q <= CAL_IDLE;
               end
            end
            default: begin
               cal_q <= CAL_IDLE;
            end
         endcase
      end
   end
   assign busy        = cal_q != CAL_IDLE;
   assign o_cal_state = cal_q;

   // startup hold until first calibration done and loop locked, once only
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         first_done_q <= 1'b0;
         released_q   <= 1'b0;
      end else begin
         if (ref_rise && cal_q == CAL_LOCK && s2_q[2]) begin
            first_done_q <= 1'b1;
         end
         if (first_done_q && s2_q[2]) begin
            released_q <= 1'b1;
         end
      end
   end
   assign hold   = !released_q;
   // bit high or pin low holds; release of either is the alignment event
   assign strobe = sync_bit_q || !s2_q[1];

   // two prescalers, halted in deep sleep
   generate
      for (genvar p = 0; p < 2; p++) begin : g_pre
         prescale_div u_pre (
            .i_clk     (i_clk),
            .i_reset_n (i_reset_n),
            .i_run     (!all_pd),
            .i_code    (pre_act_q[2*p +: 2]),
            .o_tick    (pre_tick[p])
         );
      end
   endgenerate

   // fourteen channels with own divider and driver
   generate
      for (genvar c = 0; c < `NCH; c++) begin : g_ch
         logic tick;
         if (c >= 4 && c <= 9) begin : g_sel
            assign tick = ch_act_q[c][`F_SRC] ? pre_tick[1] : pre_tick[0];
         end else if (c < 4) begin : g_lo
            assign tick = pre_tick[0];
         end else begin : g_hi
            assign tick = pre_tick[1];
         end
         assign pd_vec[c] = ch_act_q[c][`F_PD];
         assign held[c]   = hold || (strobe && !ch_act_q[c][`F_IGN]);
         assign o_out_mode[4*c +: 4] = ch_act_q[c][3:0];
         chan_div u_div (
            .i_clk     (i_clk),
            .i_reset_n (i_reset_n),
            .i_tick    (tick),
            .i_hold    (held[c]),
            .i_pd      (pd_vec[c]),
            .i_div     ({ch_act_q[c][17:16], ch_act_q[c][15:8]}),
            .i_phase   (ch_act_q[c][23:18]),
            .o_clk     (dclk[c])
         );
         // driver stage: source pick, inversion, disable and tristate
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               o_out[c]    <= 1'b0;
               o_out_oe[c] <= 1'b0;
            end else begin
               if (pd_vec[c] || held[c]) begin
                  o_out[c] <= 1'b0;
               end else if (c < 4 && ch_act_q[c][`F_SRC]) begin
                  o_out[c] <= s2_q[0] ^ ch_act_q[c][`F_INV];
               end else begin
                  o_out[c] <= dclk[c] ^ ch_act_q[c][`F_INV];
               end
               o_out_oe[c] <= !pd_vec[c] && ch_act_q[c][3:0] != `MODE_TRI;
            end
         end
      end
   endgenerate

   assign all_pd = &pd_vec;

   // deep sleep flag
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_deep_sleep <= 1'b0;
      end else begin
         o_deep_sleep <= all_pd;
      end
   end

   // read data select
   always_comb begin
      rd_d = 8'h00;
      if (i_reg_addr == `A_CAL) begin
         rd_d[`B_CAL] = cal_sh_q;
      end else if (i_reg_addr == `A_PRE) begin
         rd_d = {4'h0, pre_sh_q};
      end else if (i_reg_addr == `A_STAT) begin
         rd_d = {5'h00, o_deep_sleep, s2_q[2], busy};
      end else if (i_reg_addr == `A_SYNC) begin
         rd_d[`B_SYNC] = sync_bit_q;
      end else if (i_reg_addr == `A_COMMIT) begin
         rd_d[`B_COMMIT] = commit_q;
      end else if (ch_of(i_reg_addr) != 4'hf) begin
         rd_d = ch_sh_q[ch_of(i_reg_addr)][8*byte_of(i_reg_addr, ch_of(i_reg_addr)) +: 8];
      end
   end

   // registered read data
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rd_d;
      end
   end

   sequence s_run_start;
      $past(cal_q) == CAL_IDLE && cal_q == CAL_RUN;
   endsequence

   property p_start;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_run_start |-> $past(pend_q);
   endproperty
   a_start: assert property (p_start) else $error("calibration without request");

   property p_keep;
      @(posedge i_clk) disable iff (!i_reset_n)
      ($fell(busy) && !$past(commit_q)) |-> cal_act_q == $past(cal_act_q);
   endproperty
   a_keep: assert property (p_keep) else $error("calibrate bit cleared");

   property p_busy_min;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_run_start |-> busy [*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("calibration too short");

   property p_status;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_reg_rd && i_reg_addr == `A_STAT) |=> o_reg_rdata[`B_BUSY] == $past(busy);
   endproperty
   a_status: assert property (p_status) else $error("busy status wrong");

   property p_hold;
      @(posedge i_clk) disable iff (!i_reset_n)
      hold |=> o_out == 14'h0000;
   endproperty
   a_hold: assert property (p_hold) else $error("output before release");

   property p_commit;
      @(posedge i_clk) disable iff (!i_reset_n)
      commit_q |=> !commit_q && cal_act_q == $past(cal_sh_q);
   endproperty
   a_commit: assert property (p_commit) else $error("commit misbehaved");

   property p_sleep;
      @(posedge i_clk) disable iff (!i_reset_n)
      all_pd |=> o_deep_sleep && o_out_oe == 14'h0000;
   endproperty
   a_sleep: assert property (p_sleep) else $error("deep sleep missing");

   property p_tri;
      @(posedge i_clk) disable iff (!i_reset_n)
      (ch_act_q[0][3:0] == `MODE_TRI) |=> !o_out_oe[0];
   endproperty
   a_tri: assert property (p_tri) else $error("tristate still driving");

   property p_strobe;
      @(posedge i_clk) disable iff (!i_reset_n)
      (sync_bit_q && !ch_act_q[1][`F_IGN]) |=> !o_out[1];
   endproperty
   a_strobe: assert property (p_strobe) else $error("output during strobe");
endmodule // clock_distribution_vco_cal
`default_nettype wire

// ===== verif/clk_sink.sv
// downstream receiver that measures one channel's high and low times
`default_nettype none
module clk_sink (
   // clock
   input  wire logic i_clk,
   // observed channel
   input  wire logic i_line,
   // high time, low time and rising edge count
   output var int    o_high,
   output var int    o_low,
   output var int    o_edges
);
   timeunit 1ns;
   timeprecision 100ps;
   logic prev_q = 1'b0;
   int   cnt_q = 0;
   int   high_q = 0;
   int   low_q = 0;
   int   edge_q = 0;
   // count samples between changes of the line
   always @(posedge i_clk) begin
      prev_q <= i_line;
      cnt_q <= (i_line !== prev_q) ? 1 : cnt_q + 1;
      if (i_line === 1'b1 && prev_q === 1'b0) begin
         edge_q <= edge_q + 1;
         low_q <= cnt_q;
      end
      if (i_line === 1'b0 && prev_q === 1'b1) begin
         high_q <= cnt_q;
      end
   end
   assign o_high = high_q;
   assign o_low = low_q;
   assign o_edges = edge_q;
endmodule // clk_sink
`default_nettype wire

// ===== verif/clock_distribution_vco_cal_bench.sv
// self-checking bench for the clock distribution and calibration block
`default_nettype none
`include "clkdist_defines.svh"
module clock_distribution_vco_cal_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import clkdist_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ref_osc = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        sync_n = 1'b1;
   logic        locked = 1'b1;
   logic        nvm_done = 1'b0;
   logic [9:0]  addr = 10'h000;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic [7:0]  d;
   logic [13:0] out;
   logic [13:0] oe;
   logic [55:0] mode;
   logic        sleep;
   logic        busy;
   cal_state_t  cal_state;
   logic [31:0] seed = 32'hbd67;
   int          fails = 0;
   int          comparisons = 0;
   int          hi0, lo0, ed0, hi4, lo4, ed4, r, e;
   int          act[int];
   int          sh[int];

   // clocks: block clock and a free-running reference oscillator
   always #5 clk = ~clk;
   always #27 ref_osc = ~ref_osc;

   clock_distribution_vco_cal #(.CAL_CYCLES(16)) u_dut (
      .i_clk(clk), .i_reset_n(rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_ref_osc(ref_osc), .i_sync_n(sync_n), .i_loop_locked(locked),
      .i_nvm_load_done(nvm_done), .o_out(out), .o_out_oe(oe), .o_out_mode(mode),
      .o_deep_sleep(sleep), .o_cal_state(cal_state)
   );
   // receivers on channel 0 and channel 4
   clk_sink u_sink0 (.i_clk(clk), .i_line(out[0]), .o_high(hi0), .o_low(lo0), .o_edges(ed0));
   clk_sink u_sink4 (.i_clk(clk), .i_line(out[4]), .o_high(hi4), .o_low(lo4), .o_edges(ed4));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected half period in block clocks for a ratio and prescale
   function automatic int half(input int ratio, input int pre);
      return ratio * pre / 2;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // register write, mirrored into the shadow and committed model
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(negedge clk);
      reg_wr = 1'b1;
      addr = a;
      wdata = v;
      @(negedge clk);
      reg_wr = 1'b0;
      if (a == `A_COMMIT) act = sh;
      else sh[int'(a)] = int'(v);
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] v);
      @(negedge clk);
      reg_rd = 1'b1;
      addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   task automatic commit();
      wr(`A_COMMIT, 8'h01);
      repeat (3) @(negedge clk);
   endtask
   task automatic sync_pulse();
      wr(`A_SYNC, 8'h01);
      wr(`A_SYNC, 8'h00);
   endtask
   task automatic chan(input int c, input logic [7:0] ctl, input int dv);
      logic [9:0] a;
      logic [9:0] m;
      a = `A_CH_BASE + 10'(3 * c);
      m = 10'(dv - 1);
      wr(a, ctl);
      wr(a + 10'h001, m[7:0]);
      wr(a + 10'h002, {6'h00, m[9:8]});
   endtask
   // poll the busy flag under a bound
   task automatic wait_busy(input logic v);
      logic [7:0] s;
      for (int n = 0; n < 400; n++) begin
         rd(`A_STAT, s);
         if (s[`B_BUSY] === v) return;
      end
      chk(s[`B_BUSY], v);
      finish_test();
   endtask

   // main sequence
   initial begin
      seed = lfsr(seed);
      r = 3 + 2 * int'(seed[1:0]);
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      rd(`A_CAL, d);
      chk(d, 8'h00);
      rd(10'h123, d);
      chk(d, 8'h00);
      wr(`A_PRE, 8'h05);
      chan(0, 8'h00, r);
      chan(1, 8'h10, r);
      chan(2, `MODE_TRI, r);
      chan(3, 8'h40, r);
      chan(4, 8'h20, 1);
      commit();
      repeat (50) @(negedge clk);
      // pins stay low; enables follow only power-down and tristate
      chk({out, oe}, {14'h0000, 14'h3ff3});
      $display("test startup hold done");
      wr(`A_CAL, 8'h02);
      commit();
      wait_busy(1'b1);
      chk(cal_state, CAL_RUN);
      wait_busy(1'b0);
      chk(cal_state, CAL_IDLE);
      rd(`A_CAL, d);
      chk(d, 8'(act[int'(`A_CAL)]));
      rd(`A_COMMIT, d);
      chk(d, 8'h00);
      sync_pulse();
      repeat (100) @(negedge clk);
      chk(hi0, half(r, 4));
      chk(lo0, half(r, 4));
      chk(hi4, half(1, 4));
      chk(lo4, half(1, 4));
      for (int i = 0; i < 20; i++) begin
         @(negedge clk);
         chk(out[1] ^ out[0], 1'b1);
      end
      chk(mode[11:8], `MODE_TRI);
      chk({oe[2], oe[0]}, 2'b01);
      chk({oe[3], out[3]}, 2'b00);
      wr(`A_CH_BASE + 10'h006, 8'h03);
      repeat (5) @(negedge clk);
      chk(mode[11:8], `MODE_TRI);
      $display("test calibration and channels done");
      wr(`A_SYNC, 8'h01);
      repeat (10) @(negedge clk);
      e = ed4;
      r = ed0;
      repeat (20) @(negedge clk);
      chk({out[1:0], ed0 == r}, 3'b001);
      chk(ed4 > e, 1'b1);
      wr(`A_SYNC, 8'h00);
      repeat (40) @(negedge clk);
      chk(ed0 > r, 1'b1);
      $display("test alignment done");
      for (int k = 0; k < 3; k++) begin
         wr(`A_PRE, 8'(((k + 1) % 3) * 4 + k));
         chan(0, 8'h00, 2);
         chan(4, 8'ha0, 2);
         commit();
         sync_pulse();
         repeat (80) @(negedge clk);
         chk(hi0, half(2, 3 + k));
         chk(hi4, half(2, 3 + (k + 1) % 3));
      end
      chan(0, 8'h80, 2);
      commit();
      repeat (40) @(negedge clk);
      // reference half period of 27 ns seen by a 10 ns clock: 2 or 3 samples
      chk((hi0 == 2 || hi0 == 3) && (lo0 == 2 || lo0 == 3), 1'b1);
      $display("test prescalers done");
      wr(`A_CAL, 8'h02);
      commit();
      busy = 1'b0;
      for (int i = 0; i < 60; i++) begin
         rd(`A_STAT, d);
         busy = busy | d[`B_BUSY];
      end
      chk(busy, 1'b0);
      wr(`A_CAL, 8'h00);
      commit();
      wr(`A_CAL, 8'h02);
      commit();
      wait_busy(1'b1);
      wait_busy(1'b0);
      // stored load finishing with the calibrate bit set starts a run
      nvm_done = 1'b1;
      wait_busy(1'b1);
      chk(cal_state, CAL_RUN);
      wait_busy(1'b0);
      $display("test recalibration done");
      for (int c = 0; c < `NCH; c++) chan(c, 8'h40, 1);
      commit();
      chk(sleep, 1'b1);
      rd(`A_STAT, d);
      chk(d[2], 1'b1);
      $display("test deep sleep done");
      finish_test();
   end
endmodule // clock_distribution_vco_cal_bench
`default_nettype wire
